// >>> common/pmep_params.svh
`ifndef PMEP_PARAMS_SVH
`define PMEP_PARAMS_SVH

// ==========================================================
// Widths
`define PMEP_ADDR_W 11
`define PMEP_PORT_W 8
`define PMEP_HI_W 3
`define PMEP_ENTRY_W 10

// ==========================================================
// Entry code and field values
// Plain default; the entry word is a parameter of both ends.
`define PMEP_ENTRY_CODE 10'h1a5
`define PMEP_ADDRESS_BYTE_SELECT_LO 1'b0
`define PMEP_ADDRESS_BYTE_SELECT_HI 1'b1

// ==========================================================
// Timing counts
// System clock period in ns (125 MHz).
`define PMEP_CLK_NS 8
// Crystal periods per machine cycle.
`define PMEP_MC_XTAL 12
// Machine cycles of reset-high that reset the device.
`define PMEP_RST_MC 2
// Least crystal rising edges with reset high.
`define PMEP_RST_XTAL (`PMEP_MC_XTAL * `PMEP_RST_MC)
// Extra crystal periods the programmer adds to the reset hold.
`define PMEP_HOLD_MARGIN 2
// Crystal half period in system clocks (62.5 MHz/4 = 15.6 MHz).
`define PMEP_XTAL_HALF 4
// Crystal periods spent in the operate step of a program or verify.
`define PMEP_OP_STEPS 2

`endif

// >>> common/pmep_pkg.sv
package pmep_pkg;

  // ========================================================
  // Device operating modes, one-hot.
  typedef enum logic [3:0] {
    PMEP_DEV_RUN   = 4'h1,
    PMEP_DEV_HELD  = 4'h2,
    PMEP_DEV_SHIFT = 4'h4,
    PMEP_DEV_PROG  = 4'h8
  } pmep_dev_state_t;

  // ========================================================
  // Programmer sequencer states, one-hot.
  typedef enum logic [7:0] {
    PMEP_PRG_IDLE  = 8'h01,
    PMEP_PRG_HOLD  = 8'h02,
    PMEP_PRG_GAP   = 8'h04,
    PMEP_PRG_SHIFT = 8'h08,
    PMEP_PRG_READY = 8'h10,
    PMEP_PRG_ALO   = 8'h20,
    PMEP_PRG_AHI   = 8'h40,
    PMEP_PRG_OPER  = 8'h80
  } pmep_prg_state_t;

  // ========================================================
  // Memory operation requested of the programmer.
  typedef enum logic {
    PMEP_OP_VERIFY  = 1'b0,
    PMEP_OP_PROGRAM = 1'b1
  } pmep_op_t;

endpackage

// >>> common/pmep_if.sv
`timescale 1ns/1ps

// ==========================================================
// Pins between the device and the programmer.
interface pmep_if;
  logic crystal_input_clock; // Driven by the programmer.
  logic reset_pin; // High resets, then carries the entry stream.
  logic address_byte_select; // Low selects the low address byte.
  logic output_enable_program_strobe; // High enables verify data.
  logic vpp_on; // Programming voltage applied.
  // Address port: device side per bit, programmer as a group.
  logic [7:0] ap_dev_o;
  logic [7:0] ap_dev_oe_n;
  logic [7:0] ap_dev_pu;
  logic [7:0] ap_prg_o;
  logic ap_prg_oe_n;
  logic [7:0] ap_lvl;
  // Data port, same arrangement.
  logic [7:0] dp_dev_o;
  logic [7:0] dp_dev_oe_n;
  logic [7:0] dp_dev_pu;
  logic [7:0] dp_prg_o;
  logic dp_prg_oe_n;
  logic [7:0] dp_lvl;

  // A released pin with its pull-up reads high; a programmer drive wins
  // over a released device pin. A released pin with no pull-up reads low.
  assign ap_lvl = ap_prg_oe_n ?
                  ((ap_dev_oe_n & ap_dev_pu) | (~ap_dev_oe_n & ap_dev_o)) :
                  ap_prg_o;
  assign dp_lvl = dp_prg_oe_n ?
                  ((dp_dev_oe_n & dp_dev_pu) | (~dp_dev_oe_n & dp_dev_o)) :
                  dp_prg_o;

  modport dev (
    input crystal_input_clock, reset_pin, address_byte_select,
    input output_enable_program_strobe, vpp_on, ap_lvl, dp_lvl,
    output ap_dev_o, ap_dev_oe_n, ap_dev_pu,
    output dp_dev_o, dp_dev_oe_n, dp_dev_pu
  );

  modport prg (
    output crystal_input_clock, reset_pin, address_byte_select,
    output output_enable_program_strobe, vpp_on,
    output ap_prg_o, ap_prg_oe_n, dp_prg_o, dp_prg_oe_n,
    input ap_lvl, dp_lvl
  );
endinterface

// >>> hdl/pmep_device.sv
`timescale 1ns/1ps
`include "pmep_params.svh"

// Functional notes
// - Reset needs two machine cycles held high.
// - Ten bits, LSB first, enter programming.
// - Programmer changes bits with crystal clock.
// - Device samples entry bits on crystal clock.
// - Programming state: take address, program, verify.
// - Address port carries 11-bit address, byte-multiplexed.
// - Port pins written 1 get pull-up.
// - Select low means low address byte.
// - Data port outputs verify, inputs program.
// - Strobe high enables verify outputs.
module pmep_device #(
  parameter int ADDR_W = `PMEP_ADDR_W,
  parameter logic [`PMEP_ENTRY_W-1:0] ENTRY_CODE = `PMEP_ENTRY_CODE
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  pmep_if.dev bus,
  input wire logic [7:0] ap_latch_i,
  input wire logic [7:0] dp_latch_i,
  output logic [7:0] ap_pins_o,
  output logic [7:0] dp_pins_o,
  output pmep_pkg::pmep_dev_state_t mode_o,
  output logic code_err_o
);
  import pmep_pkg::*;

  // ========================================================
  // Constants
  localparam int RST_XTAL = `PMEP_RST_XTAL;
  localparam int HCNT_W = $clog2(RST_XTAL + 1);
  localparam int EW = `PMEP_ENTRY_W;
  localparam int BCNT_W = $clog2(EW);
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [HCNT_W-1:0] RST_MAX = HCNT_W'(RST_XTAL);
  localparam logic [BCNT_W-1:0] LAST_BIT = BCNT_W'(EW - 1);

  // ========================================================
  // Declarations
  pmep_dev_state_t state_r; // Operating mode.
  logic xtal_q_r; // Last sampled crystal level.
  logic x_rise; // Crystal rising edge seen this cycle.
  logic [HCNT_W-1:0] hcnt_r; // Consecutive high samples of reset.
  logic [EW-1:0] sh_r; // Entry shift register.
  logic [EW-1:0] sh_nxt; // Shift register with this bit added.
  logic [BCNT_W-1:0] bcnt_r; // Entry bits taken so far.
  logic [7:0] addr_lo_r; // Low address byte.
  logic [ADDR_W-9:0] addr_hi_r; // High address bits.
  logic [ADDR_W-1:0] addr; // Full programming address.
  logic strobe_q_r; // Last strobe level, for the program edge.
  logic prog_we; // One-cycle program write.
  logic verify_en; // Data port drives memory contents.
  logic [7:0] mem_r [DEPTH]; // Program memory.
  logic [7:0] dout_r; // Verify data register.
  logic in_prog; // Programming state.

  // ========================================================
  // Crystal edge detect
  // The crystal pin is taken as synchronous to clk_i, so one
  // register is enough to find its rising edge.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      xtal_q_r <= 1'b0;
    end else begin
      xtal_q_r <= bus.crystal_input_clock;
    end
  end

  assign x_rise = bus.crystal_input_clock & ~xtal_q_r;

  // ========================================================
  // Reset-high counter
  // Counts crystal rising edges with the reset pin high and
  // saturates; any low sample starts it over. Entry bits never
  // reach the limit, since ten are far fewer than the hold.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hcnt_r <= '0;
    end else if (x_rise) begin
      if (!bus.reset_pin) begin
        hcnt_r <= '0;
      end else if (hcnt_r != RST_MAX) begin
        hcnt_r <= hcnt_r + 1'b1;
      end
    end
  end

  // ========================================================
  // Entry shift register
  // Bits arrive least significant first, so each new one enters at
  // the top and the first one ends in bit 0.
  assign sh_nxt = {bus.reset_pin, sh_r[EW-1:1]};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sh_r <= '0;
      bcnt_r <= '0;
    end else if (state_r != PMEP_DEV_SHIFT) begin
      bcnt_r <= '0;
    end else if (x_rise) begin
      sh_r <= sh_nxt;
      bcnt_r <= bcnt_r + 1'b1;
    end
  end

  // ========================================================
  // Mode sequencer
  // A full reset hold wins from every mode. The crystal edge that
  // first sees reset low ends the hold; the next ten carry the code.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= PMEP_DEV_RUN;
      code_err_o <= 1'b0;
    end else begin
      code_err_o <= 1'b0;
      unique case (state_r)
        PMEP_DEV_HELD: begin
          if (x_rise && !bus.reset_pin) begin
            state_r <= PMEP_DEV_SHIFT;
          end
        end
        PMEP_DEV_SHIFT: begin
          if (hcnt_r == RST_MAX) begin
            state_r <= PMEP_DEV_HELD;
          end else if (x_rise && bcnt_r == LAST_BIT) begin
            if (sh_nxt == ENTRY_CODE) begin
              state_r <= PMEP_DEV_PROG;
            end else begin
              // A wrong code leaves the device running normally.
              state_r <= PMEP_DEV_RUN;
              code_err_o <= 1'b1;
            end
          end
        end
        default: begin
          // Run and programming modes leave only by a reset hold.
          if (hcnt_r == RST_MAX) begin
            state_r <= PMEP_DEV_HELD;
          end
        end
      endcase
    end
  end

  assign in_prog = (state_r == PMEP_DEV_PROG);
  assign mode_o = state_r;

  // ========================================================
  // Address capture
  // The port is latched every cycle of the programming state, so
  // the address follows the port while its byte is selected. Out of
  // that state the port is ignored for addressing.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_lo_r <= '0;
      addr_hi_r <= '0;
    end else if (in_prog) begin
      if (bus.address_byte_select == `PMEP_ADDRESS_BYTE_SELECT_LO) begin
        addr_lo_r <= bus.ap_lvl;
      end else begin
        addr_hi_r <= bus.ap_lvl[ADDR_W-9:0];
      end
    end
  end

  assign addr = {addr_hi_r, addr_lo_r};

  // ========================================================
  // Program and verify
  // A write takes the strobe's fall with the programming voltage on;
  // the strobe only opens the outputs when that voltage is off, so
  // the device never fights data the programmer drives.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strobe_q_r <= 1'b0;
    end else begin
      strobe_q_r <= bus.output_enable_program_strobe;
    end
  end

  assign prog_we = in_prog & bus.vpp_on & strobe_q_r
                   & ~bus.output_enable_program_strobe;
  assign verify_en = in_prog & ~bus.vpp_on
                     & bus.output_enable_program_strobe;

  // Memory holds no reset; its contents survive a device reset.
  always_ff @(posedge clk_i) begin
    if (prog_we) begin
      mem_r[addr] <= bus.dp_lvl;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dout_r <= '0;
    end else begin
      dout_r <= mem_r[addr];
    end
  end

  // ========================================================
  // Port pins
  // Normal mode: a latch bit of 1 releases the pin onto its pull-up
  // so it can be read as input; 0 pulls it low. In the other modes
  // the address port is an input and the data port drives only for
  // verify.
  always_comb begin
    if (state_r == PMEP_DEV_RUN) begin
      bus.ap_dev_oe_n = ap_latch_i;
      bus.ap_dev_pu = ap_latch_i;
      bus.dp_dev_oe_n = dp_latch_i;
      bus.dp_dev_pu = dp_latch_i;
    end else begin
      bus.ap_dev_oe_n = 8'hff;
      bus.ap_dev_pu = 8'hff;
      bus.dp_dev_oe_n = verify_en ? 8'h00 : 8'hff;
      bus.dp_dev_pu = 8'hff;
    end
  end

  assign bus.ap_dev_o = 8'h00;
  assign bus.dp_dev_o = verify_en ? dout_r : 8'h00;

  // Registered pin read-back for the core.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ap_pins_o <= '0;
      dp_pins_o <= '0;
    end else begin
      ap_pins_o <= bus.ap_lvl;
      dp_pins_o <= bus.dp_lvl;
    end
  end
endmodule // pmep_device

// >>> hdl/pmep_programmer.sv
`timescale 1ns/1ps
`include "pmep_params.svh"

module pmep_programmer #(
  parameter int ADDR_W = `PMEP_ADDR_W,
  parameter logic [`PMEP_ENTRY_W-1:0] ENTRY_CODE = `PMEP_ENTRY_CODE,
  parameter int XTAL_HALF = `PMEP_XTAL_HALF
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  pmep_if.prg bus,
  input wire logic enter_i,
  output logic ready_o,
  input wire logic op_valid_i,
  input wire pmep_pkg::pmep_op_t op_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic done_o,
  output logic [7:0] rdata_o
);
  import pmep_pkg::*;

  // ========================================================
  // Constants
  localparam int HOLD = `PMEP_RST_XTAL + `PMEP_HOLD_MARGIN;
  localparam int EW = `PMEP_ENTRY_W;
  localparam int CNT_W = $clog2(HOLD + 1);
  localparam int DIV_W = $clog2(XTAL_HALF + 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD - 1);
  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(EW - 1);
  localparam logic [CNT_W-1:0] OP_LAST = CNT_W'(`PMEP_OP_STEPS - 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(XTAL_HALF - 1);

  // ========================================================
  // Declarations
  pmep_prg_state_t state_r; // Sequencer state.
  logic [DIV_W-1:0] div_r; // Crystal half-period divider.
  logic xtal_r; // Crystal clock driven out.
  logic x_fall; // Crystal about to fall this cycle.
  logic [CNT_W-1:0] cnt_r; // Crystal periods within a state.
  logic [EW-1:0] code_r; // Entry bits still to send.
  pmep_op_t op_r; // Operation taken.
  logic [ADDR_W-1:0] addr_r; // Address taken.
  logic [7:0] wdata_r; // Program data taken.

  // ========================================================
  // Crystal clock divider
  // The crystal is made from clk_i, so every pin change but the reset
  // rise that opens the hold is timed from the cycle in which the crystal falls.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r <= '0;
      xtal_r <= 1'b0;
    end else if (div_r == DIV_LAST) begin
      div_r <= '0;
      xtal_r <= ~xtal_r;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  assign x_fall = xtal_r & (div_r == DIV_LAST);
  assign bus.crystal_input_clock = xtal_r;

  // ========================================================
  // Sequencer
  // Holds reset, leaves one low period, sends the code, and then
  // serves one operation at a time in the programming state.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= PMEP_PRG_IDLE;
      cnt_r <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state_r)
        PMEP_PRG_IDLE: begin
          if (enter_i) begin
            state_r <= PMEP_PRG_HOLD;
            cnt_r <= '0;
          end
        end
        PMEP_PRG_HOLD: begin
          if (x_fall) begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == HOLD_LAST) begin
              state_r <= PMEP_PRG_GAP;
            end
          end
        end
        PMEP_PRG_GAP: begin
          if (x_fall) begin
            state_r <= PMEP_PRG_SHIFT;
            cnt_r <= '0;
          end
        end
        PMEP_PRG_SHIFT: begin
          if (x_fall) begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == BIT_LAST) begin
              state_r <= PMEP_PRG_READY;
            end
          end
        end
        PMEP_PRG_READY: begin
          if (op_valid_i) begin
            state_r <= PMEP_PRG_ALO;
          end
        end
        PMEP_PRG_ALO: begin
          if (x_fall) begin
            state_r <= PMEP_PRG_AHI;
          end
        end
        PMEP_PRG_AHI: begin
          if (x_fall) begin
            state_r <= PMEP_PRG_OPER;
            cnt_r <= '0;
          end
        end
        PMEP_PRG_OPER: begin
          if (x_fall) begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == OP_LAST) begin
              state_r <= PMEP_PRG_READY;
              done_o <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  assign ready_o = (state_r == PMEP_PRG_READY);

  // ========================================================
  // Request capture and entry code shifting
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_r <= PMEP_OP_VERIFY;
      addr_r <= '0;
      wdata_r <= '0;
      code_r <= '0;
    end else begin
      if (ready_o && op_valid_i) begin
        op_r <= op_i;
        addr_r <= addr_i;
        wdata_r <= wdata_i;
      end
      if (state_r == PMEP_PRG_GAP) begin
        code_r <= ENTRY_CODE;
      end else if (state_r == PMEP_PRG_SHIFT && x_fall) begin
        code_r <= {1'b0, code_r[EW-1:1]};
      end
    end
  end

  // ========================================================
  // Pin drive
  // Pin changes after the reset rise that opens the hold follow crystal
  // falls, so the device samples a settled level at each rise.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus.reset_pin <= 1'b0;
      bus.address_byte_select <= `PMEP_ADDRESS_BYTE_SELECT_LO;
      bus.output_enable_program_strobe <= 1'b0;
      bus.vpp_on <= 1'b0;
      bus.ap_prg_o <= '0;
      bus.ap_prg_oe_n <= 1'b1;
      bus.dp_prg_o <= '0;
      bus.dp_prg_oe_n <= 1'b1;
      rdata_o <= '0;
    end else if (state_r == PMEP_PRG_HOLD) begin
      // The last hold fall drops reset for one whole crystal period.
      // The device needs that low rise to leave the hold, so bit 0
      // must not follow the hold directly.
      bus.reset_pin <= !(x_fall && cnt_r == HOLD_LAST);
    end else if (x_fall) begin
      unique case (state_r)
        PMEP_PRG_GAP: begin
          bus.reset_pin <= ENTRY_CODE[0];
        end
        PMEP_PRG_SHIFT: begin
          bus.reset_pin <= (cnt_r == BIT_LAST) ? 1'b0 : code_r[1];
        end
        PMEP_PRG_ALO: begin
          bus.address_byte_select <= `PMEP_ADDRESS_BYTE_SELECT_LO;
          bus.ap_prg_o <= addr_r[7:0];
          bus.ap_prg_oe_n <= 1'b0;
        end
        PMEP_PRG_AHI: begin
          bus.address_byte_select <= `PMEP_ADDRESS_BYTE_SELECT_HI;
          bus.ap_prg_o <= 8'(addr_r[ADDR_W-1:8]);
          bus.output_enable_program_strobe <= 1'b1;
          bus.vpp_on <= (op_r == PMEP_OP_PROGRAM);
          bus.dp_prg_o <= wdata_r;
          bus.dp_prg_oe_n <= (op_r != PMEP_OP_PROGRAM);
        end
        PMEP_PRG_OPER: begin
          // First period: strobe falls for both operations; a verify also reads the data.
          if (cnt_r == '0) begin
            bus.output_enable_program_strobe <= 1'b0;
            if (op_r == PMEP_OP_VERIFY) begin
              rdata_o <= bus.dp_lvl;
            end
          end else begin
            bus.vpp_on <= 1'b0;
            bus.dp_prg_oe_n <= 1'b1;
            bus.ap_prg_oe_n <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule // pmep_programmer

// >>> verification/pmep_monitor.sv
`timescale 1ns/1ps

// ==========================================================
// Link checker; sees only the pins between the two ends.
module pmep_monitor (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic crystal_input_clock,
  input wire logic reset_pin,
  input wire logic address_byte_select,
  input wire logic output_enable_program_strobe,
  input wire logic vpp_on,
  input wire logic ap_prg_oe_n,
  input wire logic [7:0] dp_dev_oe_n,
  input wire logic dp_prg_oe_n
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // ========================================================
  // Helper logic.
  logic xtal_prev_r; // Crystal level one clock ago.
  logic [4:0] hold_cnt_r; // Crystal rises seen with reset high.
  logic hold_seen_r; // A full reset hold has been seen.

  // Track the crystal so that its rises can be counted.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      xtal_prev_r <= 1'b0;
    end else begin
      xtal_prev_r <= crystal_input_clock;
    end
  end

  // Count rises while reset is high; it saturates so it cannot wrap.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_cnt_r <= 5'h00;
    end else if (!reset_pin) begin
      hold_cnt_r <= 5'h00;
    end else if (crystal_input_clock && !xtal_prev_r &&
                 hold_cnt_r != 5'h1f) begin
      hold_cnt_r <= hold_cnt_r + 5'h01;
    end
  end

  // Remember that two machine cycles of reset were given.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_seen_r <= 1'b0;
    end else if (hold_cnt_r >= 5'h18) begin
      hold_seen_r <= 1'b1;
    end
  end

  // ========================================================
  // Assertions.
  chk_xtal_half_len: assert property (
    $rose(crystal_input_clock) |-> crystal_input_clock[*4] ##1
    !crystal_input_clock) else $error("crystal high time wrong");
  chk_bit_on_fall: assert property (
    hold_seen_r && $changed(reset_pin) |-> $fell(crystal_input_clock))
    else $error("entry bit changed off a crystal fall");
  chk_hold_before_op: assert property (
    $rose(output_enable_program_strobe) |-> hold_seen_r)
    else $error("operation without reset hold");
  chk_op_reset_low: assert property (
    output_enable_program_strobe |-> !reset_pin)
    else $error("strobe while reset pin high");
  chk_addr_low_first: assert property (
    $fell(ap_prg_oe_n) |-> !address_byte_select)
    else $error("address driven without low byte select");
  chk_strobe_full_addr: assert property (
    $rose(output_enable_program_strobe) |->
    address_byte_select && !ap_prg_oe_n)
    else $error("strobe without high address part");
  chk_sel_after_low: assert property (
    $rose(address_byte_select) |-> !$past(ap_prg_oe_n, 4))
    else $error("high part without earlier low byte");
  chk_dev_drive_cause: assert property (
    dp_dev_oe_n != 8'hff |-> output_enable_program_strobe && !vpp_on)
    else $error("device drove data port outside verify");
  chk_verify_drive: assert property (
    output_enable_program_strobe && !vpp_on |-> dp_dev_oe_n == 8'h00)
    else $error("verify data not driven");
  chk_prog_data_in: assert property (
    output_enable_program_strobe && vpp_on |->
    !dp_prg_oe_n && dp_dev_oe_n == 8'hff)
    else $error("program data not taken in");

  // Main scenarios reached.
  cov_hold_done: cover property ($fell(reset_pin) && hold_seen_r);
  cov_program: cover property ($rose(output_enable_program_strobe) && vpp_on);
  cov_verify: cover property (output_enable_program_strobe && !vpp_on);
endmodule // pmep_monitor

// >>> verification/pmep_tb_top.sv
`timescale 1ns/1ps

// ==========================================================
// Bench: a good pair on bus_a, a pair with mismatched codes on bus_b.
module pmep_tb_top;
  import pmep_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic enter_a = 1'b0; // Entry request of the good pair.
  logic enter_b = 1'b0; // Entry request of the mismatched pair.
  logic op_valid = 1'b0;
  pmep_op_t op = PMEP_OP_VERIFY;
  logic [10:0] addr = 11'h000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] ap_latch = 8'h0f; // Mixed ones and zeros on the port.
  logic [7:0] dp_latch = 8'hff; // Released, so verify drive is clear.
  logic [7:0] ap_pins_a, dp_pins_a, rdata_a;
  logic [7:0] rdata_b; // Verify data seen by the refused programmer.
  pmep_dev_state_t mode_a, mode_b;
  logic err_a, err_b, ready_a, ready_b, done_a;
  int fails = 0;
  int n_checks = 0;
  logic [10:0] addrs [4] = '{11'h7ff, 11'h0ff, 11'h700, 11'h000};
  logic [7:0] datas [4] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};

  pmep_if bus_a();
  pmep_if bus_b();

  pmep_device u_pmep_device (.clk_i(clk_i), .nrst_i(nrst_i), .bus(bus_a),
    .ap_latch_i(ap_latch), .dp_latch_i(dp_latch), .ap_pins_o(ap_pins_a),
    .dp_pins_o(dp_pins_a), .mode_o(mode_a), .code_err_o(err_a));
  pmep_programmer u_pmep_programmer (.clk_i(clk_i), .nrst_i(nrst_i),
    .bus(bus_a), .enter_i(enter_a), .ready_o(ready_a),
    .op_valid_i(op_valid), .op_i(op), .addr_i(addr), .wdata_i(wdata),
    .done_o(done_a), .rdata_o(rdata_a));
  pmep_device u_pmep_device_b (.clk_i(clk_i), .nrst_i(nrst_i), .bus(bus_b),
    .ap_latch_i(ap_latch), .dp_latch_i(dp_latch), .ap_pins_o(),
    .dp_pins_o(), .mode_o(mode_b), .code_err_o(err_b));
  // The far end sends a code that the device must refuse.
  pmep_programmer #(.ENTRY_CODE(10'h0a5)) u_pmep_programmer_b (
    .clk_i(clk_i), .nrst_i(nrst_i), .bus(bus_b), .enter_i(enter_b),
    .ready_o(ready_b), .op_valid_i(op_valid), .op_i(op), .addr_i(addr),
    .wdata_i(wdata), .done_o(), .rdata_o(rdata_b));
  pmep_monitor u_pmep_monitor (.clk_i(clk_i), .nrst_i(nrst_i),
    .crystal_input_clock(bus_a.crystal_input_clock),
    .reset_pin(bus_a.reset_pin),
    .address_byte_select(bus_a.address_byte_select),
    .output_enable_program_strobe(bus_a.output_enable_program_strobe),
    .vpp_on(bus_a.vpp_on), .ap_prg_oe_n(bus_a.ap_prg_oe_n),
    .dp_dev_oe_n(bus_a.dp_dev_oe_n), .dp_prg_oe_n(bus_a.dp_prg_oe_n));

  // 125 MHz system clock.
  always #4 clk_i = ~clk_i;

  // ========================================================
  // Shared tasks.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Compare one byte-wide result.
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compare a device mode.
  task automatic cmp_mode(input pmep_dev_state_t got,
                          input pmep_dev_state_t exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait: 0 ready, 1 done, 2 code error of the second pair.
  task automatic wait_for(input int sel);
    for (int i = 0; i < 2000; i++) begin
      @(negedge clk_i);
      if (sel == 0 && ready_a === 1'b1) return;
      if (sel == 1 && done_a === 1'b1) return;
      if (sel == 2 && err_b === 1'b1) return;
    end
    fails++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    finish_test();
  endtask

  // One program or verify, offered for one clock, then waited out.
  task automatic do_op(input pmep_op_t o, input logic [10:0] a,
                       input logic [7:0] d);
    @(negedge clk_i);
    op_valid = 1'b1;
    op = o;
    addr = a;
    wdata = d;
    @(negedge clk_i);
    op_valid = 1'b0;
    wait_for(1);
  endtask

  // ========================================================
  // Scenarios.
  task automatic t_run_pins();
    repeat (4) @(negedge clk_i);
    cmp_mode(mode_a, PMEP_DEV_RUN);
    cmp_val(ap_pins_a, 8'h0f);
    cmp_val(dp_pins_a, 8'hff);
    ap_latch = 8'hf0;
    repeat (4) @(negedge clk_i);
    cmp_val(bus_a.ap_lvl, 8'hf0);
  endtask

  // A wrong code leaves the device running; ready_b is checked still low two clocks after the code error.
  task automatic t_bad_code();
    enter_b = 1'b1;
    wait_for(2);
    repeat (2) @(negedge clk_i);
    cmp_mode(mode_b, PMEP_DEV_RUN);
    cmp_val({7'h00, ready_b}, 8'h00);
  endtask

  task automatic t_entry();
    enter_a = 1'b1;
    wait_for(0);
    cmp_mode(mode_a, PMEP_DEV_PROG);
    cmp_val({7'h00, err_a}, 8'h00);
  endtask

  // Edge addresses differ only in one byte half, so a lost part shows.
  task automatic t_prog_verify();
    for (int i = 0; i < 4; i++) begin
      do_op(PMEP_OP_PROGRAM, addrs[i], datas[i]);
    end
    for (int i = 0; i < 4; i++) begin
      do_op(PMEP_OP_VERIFY, addrs[i], 8'h00);
      cmp_val(rdata_a, datas[i]);
      // The refused device keeps its data port on the pull-ups.
      cmp_val(rdata_b, 8'hff);
    end
  endtask

  // ========================================================
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    nrst_i = 1'b1;
    t_run_pins();
    t_bad_code();
    t_entry();
    t_prog_verify();
    finish_test();
  end
endmodule // pmep_tb_top
